// ===== verilog/snd_pkg.sv
// constants, field layouts and carrier types for the signal and noise detector configuration
package snd_pkg;

	// ==========================================================
	// register offsets (byte addresses on the plain port)
	localparam logic [7:0] SND_OFS_SLICER   = 8'h3E;
	localparam logic [7:0] SND_OFS_RUN_THR  = 8'h3F;
	localparam logic [7:0] SND_OFS_WAKE_THR = 8'h40;
	localparam logic [7:0] SND_OFS_LOW_THR  = 8'h41;
	localparam logic [7:0] SND_OFS_RANGE    = 8'h42;
	localparam logic [7:0] SND_OFS_DET_CTL  = 8'h43;
	localparam logic [7:0] SND_OFS_NOISE_TH = 8'h44;
	localparam logic [7:0] SND_OFS_NOISE_CT = 8'h45;
	localparam logic [7:0] SND_OFS_STATUS   = 8'h46;

	// ==========================================================
	// reset values
	localparam logic [7:0] SND_RST_SLICER   = 8'h02;
	localparam logic [7:0] SND_RST_THR      = 8'h00;
	localparam logic [7:0] SND_RST_RANGE    = 8'h3F;
	localparam logic [7:0] SND_RST_DET_CTL  = 8'h00;
	localparam logic [7:0] SND_RST_NOISE_CT = 8'h07;

	// ==========================================================
	// field positions
	localparam int SND_SLC_SCALE_LSB = 3;
	localparam int SND_RNG_ASK_LSB   = 4;
	localparam int SND_RNG_FSK_LSB   = 2;
	localparam int SND_RNG_LOW_LSB   = 0;
	localparam int SND_CTL_SRC_BIT   = 2;
	localparam int SND_CTL_WCNT_BIT  = 1;
	localparam int SND_CTL_RCNT_BIT  = 0;
	localparam int SND_ND_RANGE_LSB  = 6;
	localparam int SND_ND_MODE_LSB   = 4;
	localparam int SND_ND_FRAC_LSB   = 2;
	localparam int SND_ND_SLEW_LSB   = 0;

	// detector modes
	typedef enum logic [1:0] {
		SND_MODE_SQUELCH = 2'h0,
		SND_MODE_NOISE   = 2'h1,
		SND_MODE_BOTH    = 2'h2,
		SND_MODE_GATED   = 2'h3
	} snd_mode_t;

	// ==========================================================
	// register port carrier
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} snd_req_t;

	// measured values from the baseband; power, low_power and noise are sampled on the valid strobe, the flags every clock
	typedef struct packed {
		logic [23:0] power;       // signal power
		logic [23:0] low_power;   // signal for minimal usable deviation
		logic [23:0] noise;       // noise detector output
		logic        valid;       // new sample this cycle
		logic        half_bit;    // half-bit tick from data recovery
		logic        wakeup;      // receiver in wakeup search
		logic        fsk;         // fsk modulation when high
	} snd_meas_t;

endpackage : snd_pkg

// ===== verilog/snd_cfg.sv
// register bank and threshold decision for the signal and noise detector
`timescale 1ns/100ps
`default_nettype none
module snd_cfg
	import snd_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire snd_req_t    req,
	input  wire snd_meas_t   meas,
	output logic      [7:0]  rdata,
	output logic      [2:0]  slicer_manual_bw,
	output logic      [1:0]  slicer_bw_scale,
	output logic      [1:0]  noise_peak_slew,
	output logic      [1:0]  noise_threshold_fraction,
	output logic      [1:0]  noise_range_select,
	output logic      [1:0]  detector_mode_select,
	output logic             signal_detect,
	output logic             noise_detect
);

	// ==========================================================
	// registers
	logic [7:0]  slicer_q;
	logic [7:0]  run_thr_q;
	logic [7:0]  wake_thr_q;
	logic [7:0]  low_thr_q;
	logic [7:0]  range_q;
	logic [7:0]  det_ctl_q;
	logic [7:0]  noise_th_q;
	logic [7:0]  noise_ct_q;
	logic [23:0] readout_q;
	logic        sig_raw_q;
	logic        sig_held_q;
	logic        sig_armed_q;
	logic        noise_q;
	logic        low_ok_q;

	// write path; reserved bits are stored as zero so they read back zero
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			slicer_q   <= SND_RST_SLICER;
			run_thr_q  <= SND_RST_THR;
			wake_thr_q <= SND_RST_THR;
			low_thr_q  <= SND_RST_THR;
			range_q    <= SND_RST_RANGE;
			det_ctl_q  <= SND_RST_DET_CTL;
			noise_th_q <= SND_RST_THR;
			noise_ct_q <= SND_RST_NOISE_CT;
		end else if (req.wr) begin
			unique case (req.addr)
				SND_OFS_SLICER:   slicer_q   <= {3'h0, req.wdata[4:0]};
				SND_OFS_RUN_THR:  run_thr_q  <= req.wdata;
				SND_OFS_WAKE_THR: wake_thr_q <= req.wdata;
				SND_OFS_LOW_THR:  low_thr_q  <= req.wdata;
				SND_OFS_RANGE:    range_q    <= {2'h0, req.wdata[5:0]};
				SND_OFS_DET_CTL:  det_ctl_q  <= {5'h00, req.wdata[2:0]};
				SND_OFS_NOISE_TH: noise_th_q <= req.wdata;
				SND_OFS_NOISE_CT: noise_ct_q <= req.wdata;
				default: ;                         // unmapped writes are dropped
			endcase
		end
	end

	// read path: the threshold registers are write-only and read as zero
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			unique case (req.addr)
				SND_OFS_SLICER:   rdata <= slicer_q;
				SND_OFS_RANGE:    rdata <= range_q;
				SND_OFS_DET_CTL:  rdata <= det_ctl_q;
				SND_OFS_STATUS:   rdata <= {4'h0, low_ok_q, noise_q, sig_raw_q, signal_detect};
				default:          rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// ==========================================================
	// field outputs toward the slicer and the noise detector
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			slicer_manual_bw         <= SND_RST_SLICER[2:0];
			slicer_bw_scale          <= SND_RST_SLICER[4:3];
			noise_range_select       <= SND_RST_NOISE_CT[7:6];
			detector_mode_select     <= SND_RST_NOISE_CT[5:4];
			noise_threshold_fraction <= SND_RST_NOISE_CT[3:2];
			noise_peak_slew          <= SND_RST_NOISE_CT[1:0];
		end else begin
			slicer_manual_bw         <= slicer_q[2:0];
			slicer_bw_scale          <= slicer_q[SND_SLC_SCALE_LSB +: 2];
			noise_range_select       <= noise_ct_q[SND_ND_RANGE_LSB +: 2];
			detector_mode_select     <= noise_ct_q[SND_ND_MODE_LSB +: 2];
			noise_threshold_fraction <= noise_ct_q[SND_ND_FRAC_LSB +: 2];
			noise_peak_slew          <= noise_ct_q[SND_ND_SLEW_LSB +: 2];
		end
	end

	// ==========================================================
	// threshold scaling; the ask code 10 exponent is 7+6 = 13
	logic [7:0]  act_thr;
	logic [4:0]  sig_exp;
	logic [4:0]  low_exp;
	logic [23:0] sig_lim;
	logic [23:0] low_lim;
	logic [1:0]  ask_code;
	logic [1:0]  fsk_code;
	logic [1:0]  low_code;
	logic [3:0]  nd_shift;
	logic [23:0] noise_lim;

	always_comb begin
		ask_code = range_q[SND_RNG_ASK_LSB +: 2];
		fsk_code = range_q[SND_RNG_FSK_LSB +: 2];
		low_code = range_q[SND_RNG_LOW_LSB +: 2];
		act_thr  = meas.wakeup ? wake_thr_q : run_thr_q;
		unique case (ask_code)
			2'h0: sig_exp = 5'h06;
			2'h1: sig_exp = 5'h07;
			2'h2: sig_exp = 5'h0D;
			2'h3: sig_exp = 5'h08;
		endcase
		if (meas.fsk) begin
			sig_exp = {2'h0, fsk_code, 1'b0} + 5'h02;
		end
		low_exp  = {2'h0, low_code, 1'b0} + 5'h02;
		sig_lim  = 24'({16'h0000, act_thr} << sig_exp);
		low_lim  = 24'({16'h0000, low_thr_q} << low_exp);
		// noise range codes step the exponent down from 7 to 4
		nd_shift = 4'h7 - {2'h0, noise_ct_q[SND_ND_RANGE_LSB +: 2]};
		noise_lim = 24'({16'h0000, noise_th_q} << nd_shift);
	end

	// ==========================================================
	// detection decisions, taken on each measurement strobe
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sig_raw_q <= 1'b0;
			noise_q   <= 1'b0;
			low_ok_q  <= 1'b0;
		end else if (meas.valid) begin
			sig_raw_q <= meas.power > sig_lim;
			noise_q   <= meas.noise > noise_lim;
			// low threshold only matters in the gated mode
			low_ok_q  <= (noise_ct_q[5:4] == SND_MODE_GATED) ?
				(meas.low_power > low_lim) : 1'b1;
		end
	end

	// readout source select, captured per sample
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			readout_q <= 24'h000000;
		end else if (meas.valid) begin
			readout_q <= det_ctl_q[SND_CTL_SRC_BIT] ? meas.low_power : meas.power;
		end
	end

	// half-bit persistence: the condition must hold across a full half-bit tick interval.
	// armed marks the first tick seen with the condition up, held the next one; a single
	// tick is not enough because the condition may have risen just before it
	logic cnt_en;
	assign cnt_en = meas.wakeup ? det_ctl_q[SND_CTL_WCNT_BIT]
	                            : det_ctl_q[SND_CTL_RCNT_BIT];

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sig_held_q  <= 1'b0;
			sig_armed_q <= 1'b0;
		end else begin
			if (!sig_raw_q) begin
				sig_armed_q <= 1'b0;
				sig_held_q  <= 1'b0;
			end else if (meas.half_bit) begin
				sig_armed_q <= 1'b1;
				sig_held_q  <= sig_armed_q;
			end
		end
	end

	// final outputs, gated by detector mode
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			signal_detect <= 1'b0;
			noise_detect  <= 1'b0;
		end else begin
			signal_detect <= (noise_ct_q[5:4] != SND_MODE_NOISE) && sig_raw_q &&
				(!cnt_en || sig_held_q);
			noise_detect  <= (noise_ct_q[5:4] != SND_MODE_SQUELCH) && noise_q &&
				low_ok_q;
		end
	end

endmodule : snd_cfg
`default_nettype wire

// ===== tb/snd_cfg_checker.sv
// checker for the signal and noise detector register bank
`timescale 1ns/100ps
`default_nettype none
module snd_cfg_checker
	import snd_pkg::*;
(
	input wire logic       clock,
	input wire logic       rst_n,
	input wire snd_req_t   req,
	input wire snd_meas_t  meas,
	input wire logic [7:0] rdata,
	input wire logic [2:0] slicer_manual_bw,
	input wire logic [1:0] slicer_bw_scale,
	input wire logic [1:0] noise_peak_slew,
	input wire logic [1:0] noise_threshold_fraction,
	input wire logic [1:0] noise_range_select,
	input wire logic [1:0] detector_mode_select,
	input wire logic       signal_detect,
	input wire logic       noise_detect
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic w_slc;
	logic w_nd;
	logic r_wo;
	// ==========
	// decoded requests, kept apart so each property stays short
	assign w_slc = req.wr && req.addr == SND_OFS_SLICER;
	assign w_nd  = req.wr && req.addr == SND_OFS_NOISE_CT;
	assign r_wo  = req.rd && (req.addr == SND_OFS_RUN_THR || req.addr == SND_OFS_NOISE_TH);
	property p_scale; w_slc |-> ##2 slicer_bw_scale == $past(req.wdata[4:3], 2); endproperty
	a_scale: assert property (p_scale) else $error("slicer scale not taken");
	property p_bw; w_slc |-> ##2 slicer_manual_bw == $past(req.wdata[2:0], 2); endproperty
	a_bw: assert property (p_bw) else $error("manual bandwidth not taken");
	// a field moves only two edges after its own write
	property p_hold; !$past(w_slc, 2) |-> $stable(slicer_bw_scale); endproperty
	a_hold: assert property (p_hold) else $error("slicer scale moved unwritten");
	property p_rng; w_nd |-> ##2 noise_range_select == $past(req.wdata[7:6], 2); endproperty
	a_rng: assert property (p_rng) else $error("noise range not taken");
	property p_mode; w_nd |-> ##2 detector_mode_select == $past(req.wdata[5:4], 2); endproperty
	a_mode: assert property (p_mode) else $error("detector mode not taken");
	property p_frac; w_nd |-> ##2 noise_threshold_fraction == $past(req.wdata[3:2], 2); endproperty
	a_frac: assert property (p_frac) else $error("noise fraction not taken");
	property p_slew; w_nd |-> ##2 noise_peak_slew == $past(req.wdata[1:0], 2); endproperty
	a_slew: assert property (p_slew) else $error("peak slew not taken");
	property p_wo; r_wo |=> rdata == 8'h00; endproperty
	a_wo: assert property (p_wo) else $error("write-only register read back");
	// settled squelch and noise modes gate the other detector off
	property p_sq; detector_mode_select == SND_MODE_SQUELCH [*3] |-> !noise_detect; endproperty
	a_sq: assert property (p_sq) else $error("noise detect in squelch mode");
	property p_nd; detector_mode_select == SND_MODE_NOISE [*3] |-> !signal_detect; endproperty
	a_nd: assert property (p_nd) else $error("signal detect in noise mode");
	c_sig: cover property (signal_detect);
	c_noise: cover property (noise_detect);
	c_gated: cover property (detector_mode_select == SND_MODE_GATED && noise_detect);
endmodule : snd_cfg_checker
bind snd_cfg snd_cfg_checker chk (.*);
`default_nettype wire

// ===== tb/tb_snd_cfg.sv
// self-checking bench for the signal and noise detector register bank
`timescale 1ns/100ps
`default_nettype none
module tb_snd_cfg;
	import snd_pkg::*;
	logic       clock = 1'b0;
	logic       rst_n = 1'b0;
	snd_req_t   r     = '0;
	snd_meas_t  m     = '0;
	logic [7:0] rdata;
	logic [2:0] bw;
	logic [1:0] sc, slew, frac, rng, mode;
	logic       sdet, ndet;
	int         mismatches = 0;
	int         samples_checked = 0;
	snd_cfg dut (.clock(clock), .rst_n(rst_n), .req(r), .meas(m), .rdata(rdata),
		.slicer_manual_bw(bw), .slicer_bw_scale(sc), .noise_peak_slew(slew),
		.noise_threshold_fraction(frac), .noise_range_select(rng),
		.detector_mode_select(mode), .signal_detect(sdet), .noise_detect(ndet));
	always #25 clock = ~clock;
	// ==========
	// shared bus and compare tasks
	task automatic test_done();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock) r <= '{a, d, 1'b1, 1'b0};
		@(posedge clock) r <= '0;
		@(posedge clock) #1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock) r <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock) r <= '0;
		#1 chk("rdata", e, rdata);
	endtask : rd
	// one measurement strobe, then a check of the chosen detector two edges later
	task automatic smp(input logic [23:0] p, lp, n, input logic nd, input logic e);
		@(posedge clock) {m.power, m.low_power, m.noise, m.valid} <= {p, lp, n, 1'b1};
		@(posedge clock) m.valid <= 1'b0;
		// the decision lands one edge after the strobe is taken, the output one edge later
		@(posedge clock);
		#1 chk(nd ? "noise_detect" : "signal_detect", {7'h00, e}, {7'h00, nd ? ndet : sdet});
	endtask : smp
	task automatic t_fields();
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 6; j++) begin
				wr(SND_OFS_SLICER, 8'(i * 8 + j));
				chk("scale", 8'(i), {6'h00, sc});
				chk("manual_bw", 8'(j), {5'h00, bw});
				rd(SND_OFS_SLICER, 8'(i * 8 + j));
			end
			wr(SND_OFS_NOISE_CT, 8'(i * 8'h55));
			chk("range", 8'(i), {6'h00, rng});
			chk("mode", 8'(i), {6'h00, mode});
			chk("fraction", 8'(i), {6'h00, frac});
			chk("slew", 8'(i), {6'h00, slew});
		end
	endtask : t_fields
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		#1 chk("scale", 8'h00, {6'h00, sc});
		chk("manual_bw", 8'h02, {5'h00, bw});
		chk("nd_fields", 8'h07, {rng, mode, frac, slew});
		rd(SND_OFS_SLICER, SND_RST_SLICER);
		rd(SND_OFS_RANGE, 8'h3F);
		for (int k = 8'h3F; k < 8'h46; k++) if (k != 8'h42) rd(8'(k), 8'h00);
		rd(8'h50, 8'h00); // unmapped place reads zero
		t_fields();
		wr(SND_OFS_DET_CTL, 8'hFF);
		rd(SND_OFS_DET_CTL, 8'h07);
		// fsk range code 00 makes run threshold 4 worth 16, wakeup 8 worth 32
		m.fsk <= 1'b1;
		wr(SND_OFS_DET_CTL, 8'h00);
		wr(SND_OFS_NOISE_CT, 8'h00);
		wr(SND_OFS_RANGE, 8'h00);
		wr(SND_OFS_RUN_THR, 8'h04);
		wr(SND_OFS_WAKE_THR, 8'h08);
		smp(24'd17, 0, 0, 0, 1);
		smp(24'd16, 0, 0, 0, 0);
		m.wakeup <= 1'b1;
		smp(24'd17, 0, 0, 0, 0);
		smp(24'd33, 0, 0, 0, 1);
		{m.wakeup, m.fsk} <= 2'b00;
		smp(24'd256, 0, 0, 0, 0);
		smp(24'd257, 0, 0, 0, 1);
		// noise threshold 1 at range code 11 is worth 16
		wr(SND_OFS_NOISE_TH, 8'h01);
		wr(SND_OFS_NOISE_CT, 8'hD0);
		smp(24'd257, 0, 24'd17, 0, 0);
		smp(24'd0, 0, 24'd17, 1, 1);
		smp(24'd0, 0, 24'd16, 1, 0);
		wr(SND_OFS_NOISE_CT, 8'hC0);
		smp(24'd0, 0, 24'd17, 1, 0);
		wr(SND_OFS_NOISE_CT, 8'hE0);
		smp(24'd0, 0, 24'd17, 1, 1);
		// gated mode: low threshold 1 at code 00 is worth 4
		wr(SND_OFS_LOW_THR, 8'h01);
		wr(SND_OFS_NOISE_CT, 8'hF0);
		smp(24'd0, 24'd4, 24'd17, 1, 0);
		smp(24'd0, 24'd5, 24'd17, 1, 1);
		// run counter: detection waits for two half-bit ticks
		wr(SND_OFS_NOISE_CT, 8'h00);
		m.fsk <= 1'b1;
		smp(24'd0, 0, 0, 0, 0);
		wr(SND_OFS_DET_CTL, 8'h01);
		smp(24'd17, 0, 0, 0, 0);
		repeat (2) begin
			@(posedge clock) m.half_bit <= 1'b1;
			@(posedge clock) m.half_bit <= 1'b0;
			repeat (3) @(posedge clock);
		end
		#1 chk("signal_detect", 8'h01, {7'h00, sdet});
		test_done();
	end
endmodule : tb_snd_cfg
`default_nettype wire
